/* File: hw/rtd_regs.sv */
// Purpose: error status word, configuration word, fault values and result registers
// Assumes: serial frame decoder presents one register access per request cycle
// Notes:   reads answer one cycle after the request
`timescale 1ns/10ps
module rtd_regs (
    // clock and reset
    input  wire logic                   mclk,
    input  wire logic                   srst,
    // register access
    input  wire rtd_pkg::rtd_req_t      req,
    output logic [15:0]                 rd_data_r,
    output logic                        rd_valid_r,
    output logic                        addr_err_r,
    // error conditions
    input  wire rtd_pkg::rtd_err_t      err,
    input  wire logic [3:0]             in_err,
    // measurements
    input  wire logic [3:0]             meas_valid,
    input  wire logic [63:0]            meas_word,
    input  wire logic [127:0]           meas_float,
    // memory save
    input  wire logic                   save_req,
    output logic                        save_go_r,
    output logic                        save_refused_r,
    // indicator
    output logic                        error_indicator_lamp_r
);
    import rtd_pkg::*;

    logic [15:0] cfg_r;
    logic [15:0] status_r;
    logic [15:0] status_nxt;
    logic [15:0] fault_r  [RTD_INPUTS];
    logic [15:0] word_r   [RTD_INPUTS];
    logic [31:0] float_r  [RTD_INPUTS];
    logic [15:0] rd_nxt;
    logic        hit;
    logic [15:0] off_w;
    logic [15:0] off_f;
    logic [15:0] off_v;
    logic [3:0]  lamp_en;

    function automatic logic [31:0] to_float(input logic [15:0] v);
        logic [15:0] m;
        logic [4:0]  e;
        logic [38:0] s;
        logic [31:0] f;
        m = v[15] ? 16'(-v) : v;
        e = 5'h00;
        f = 32'h0000_0000;
        for (int k = 0; k < 16; k++) begin
            if (m[k]) begin
                e = 5'(k);
            end
        end
        s = {m, 23'h0} >> e;
        if (m != 16'h0000) begin
            f = {v[15], 8'(e) + RTD_F32_BIAS, s[22:0]};
        end
        return f;
    endfunction : to_float

    // ****************************************
    // status word
    // ****************************************
    always_comb begin
        status_nxt               = 16'h0000;
        status_nxt[RTD_B_ACQ3]   = err.acq3;
        status_nxt[RTD_B_CRC3]   = err.crc3;
        status_nxt[RTD_B_SUPPLY] = err.supply;
        status_nxt[RTD_B_RX]     = err.rx;
        status_nxt[RTD_B_MEM4]   = err.mem4;
        status_nxt[RTD_B_RTD4]   = err.rtd4;
        status_nxt[RTD_B_WIRE4]  = err.wire4 & err.three_wire4;
        status_nxt[RTD_B_ACQ4]   = err.acq4;
        status_nxt[RTD_B_CRC4]   = err.crc4;
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            status_r <= 16'h0000;
        end else begin
            status_r <= status_nxt;
        end
    end

    // ****************************************
    // configuration and fault values
    // ****************************************
    always_ff @(posedge mclk) begin
        if (srst) begin
            cfg_r <= RTD_CFG_RST;
        end else if (req.wr && req.addr == RTD_CFG_ADDR) begin
            cfg_r <= req.wdata;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            for (int i = 0; i < RTD_INPUTS; i++) begin
                fault_r[i] <= RTD_FAULT_RST;
            end
        end else begin
            for (int i = 0; i < RTD_INPUTS; i++) begin
                if (req.wr && req.addr == RTD_FAULT_ADDR + 16'(i)) begin
                    fault_r[i] <= req.wdata;
                end
            end
        end
    end

    // ****************************************
    // results with fault substitution
    // ****************************************
    always_ff @(posedge mclk) begin
        if (srst) begin
            for (int i = 0; i < RTD_INPUTS; i++) begin
                word_r[i]  <= 16'h0000;
                float_r[i] <= 32'h0000_0000;
            end
        end else begin
            for (int i = 0; i < RTD_INPUTS; i++) begin
                if (in_err[i]) begin
                    if (!cfg_r[3 - i]) begin
                        word_r[i]  <= fault_r[i];
                        float_r[i] <= to_float(fault_r[i]);
                    end
                end else if (meas_valid[i]) begin
                    word_r[i]  <= meas_word[16*i +: 16];
                    float_r[i] <= meas_float[32*i +: 32];
                end
            end
        end
    end

    // ****************************************
    // read path
    // ****************************************
    always_comb begin
        off_w  = req.addr - RTD_WORD_ADDR;
        off_f  = req.addr - RTD_FLOAT_ADDR;
        off_v  = req.addr - RTD_FAULT_ADDR;
        rd_nxt = 16'h0000;
        hit    = 1'b1;
        if (req.addr == RTD_STATUS_ADDR) begin
            rd_nxt = status_r;
        end else if (req.addr == RTD_CFG_ADDR) begin
            rd_nxt = cfg_r;
        end else if (off_w < 16'(RTD_INPUTS)) begin
            rd_nxt = word_r[off_w[1:0]];
        end else if (off_f < 16'(2 * RTD_INPUTS)) begin
            if (off_f[0] ^ cfg_r[RTD_CFG_SWAP]) begin
                rd_nxt = float_r[off_f[2:1]][15:0];
            end else begin
                rd_nxt = float_r[off_f[2:1]][31:16];
            end
        end else if (off_v < 16'(RTD_INPUTS)) begin
            rd_nxt = fault_r[off_v[1:0]];
        end else begin
            hit = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            rd_data_r  <= 16'h0000;
            rd_valid_r <= 1'b0;
            addr_err_r <= 1'b0;
        end else begin
            rd_valid_r <= req.rd;
            addr_err_r <= (req.rd | req.wr) & ~hit;
            rd_data_r  <= req.rd ? rd_nxt : 16'h0000;
        end
    end

    // ****************************************
    // lamp and memory save
    // ****************************************
    always_comb begin
        for (int i = 0; i < RTD_INPUTS; i++) begin
            lamp_en[i] = ~cfg_r[RTD_CFG_LAMP + 3 - i];
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            error_indicator_lamp_r <= 1'b0;
        end else begin
            error_indicator_lamp_r <= |(in_err & lamp_en);
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            save_go_r      <= 1'b0;
            save_refused_r <= 1'b0;
        end else begin
            save_go_r      <= save_req & ~status_r[RTD_B_CRC3] & ~status_r[RTD_B_CRC4];
            save_refused_r <= save_req & (status_r[RTD_B_CRC3] | status_r[RTD_B_CRC4]);
        end
    end

    // ****************************************
    // checks
    // ****************************************
    sequence s_cfg_write;
        req.wr && req.addr == RTD_CFG_ADDR;
    endsequence

    sequence s_float_read;
        req.rd && req.addr == RTD_FLOAT_ADDR;
    endsequence

    sequence s_crc_clear;
        !status_r[RTD_B_CRC3] && !status_r[RTD_B_CRC4];
    endsequence

    a_acq3_track: assert property (@(posedge mclk) disable iff (srst)
        ##1 status_r[RTD_B_ACQ3] == $past(err.acq3)) else $error("acq3 status wrong");
    a_crc_blocks: assert property (@(posedge mclk) disable iff (srst)
        save_req && (status_r[RTD_B_CRC3] || status_r[RTD_B_CRC4]) |=> !save_go_r && save_refused_r)
        else $error("save not blocked");
    a_wire_gate: assert property (@(posedge mclk) disable iff (srst)
        !err.three_wire4 |=> !status_r[RTD_B_WIRE4]) else $error("wire bit set in two-wire");
    a_acq4_track: assert property (@(posedge mclk) disable iff (srst)
        err.acq4 ##1 err.acq4 |-> status_r[RTD_B_ACQ4]) else $error("acq4 status wrong");
    a_swap_order: assert property (@(posedge mclk) disable iff (srst)
        s_float_read ##0 !cfg_r[RTD_CFG_SWAP]
        |=> {rd_data_r, 16'h0000} == ($past(float_r[0]) & 32'hffff_0000)) else $error("float word order wrong");
    a_lamp_mask: assert property (@(posedge mclk) disable iff (srst)
        in_err[0] && !cfg_r[7] |=> error_indicator_lamp_r) else $error("lamp not lit");
    a_fault_subst: assert property (@(posedge mclk) disable iff (srst)
        in_err[0] && !cfg_r[3] |=> word_r[0] == $past(fault_r[0])) else $error("fault value missing");
    a_hold_last: assert property (@(posedge mclk) disable iff (srst)
        in_err[3] && cfg_r[0] |=> $stable(word_r[3])) else $error("last good not held");
    a_status_ro: assert property (@(posedge mclk) disable iff (srst)
        req.wr && req.addr == RTD_STATUS_ADDR |=> status_r[RTD_B_ACQ3] == $past(err.acq3)
        && status_r[RTD_B_CRC4] == $past(err.crc4)) else $error("status written");
    a_cfg_store: assert property (@(posedge mclk) disable iff (srst)
        s_cfg_write |=> cfg_r == $past(req.wdata)) else $error("cfg not stored");

    // ****************************************
    // status and memory save checks
    // ****************************************
    a_crc3_track: assert property (@(posedge mclk) disable iff (srst)
        ##1 status_r[RTD_B_CRC3] == $past(err.crc3)) else $error("crc3 status wrong");
    a_supply_track: assert property (@(posedge mclk) disable iff (srst)
        ##1 status_r[RTD_B_SUPPLY] == $past(err.supply)) else $error("supply status wrong");
    a_rx_track: assert property (@(posedge mclk) disable iff (srst)
        ##1 status_r[RTD_B_RX] == $past(err.rx)) else $error("rx status wrong");
    a_mem4_track: assert property (@(posedge mclk) disable iff (srst)
        ##1 status_r[RTD_B_MEM4] == $past(err.mem4)) else $error("mem4 status wrong");
    a_rtd4_track: assert property (@(posedge mclk) disable iff (srst)
        ##1 status_r[RTD_B_RTD4] == $past(err.rtd4)) else $error("rtd4 status wrong");
    a_wire_pass: assert property (@(posedge mclk) disable iff (srst)
        err.wire4 && err.three_wire4 |=> status_r[RTD_B_WIRE4]) else $error("wire bit missing");
    a_acq4_clear: assert property (@(posedge mclk) disable iff (srst)
        !err.acq4 |=> !status_r[RTD_B_ACQ4]) else $error("acq4 bit stuck");
    a_crc4_track: assert property (@(posedge mclk) disable iff (srst)
        ##1 status_r[RTD_B_CRC4] == $past(err.crc4)) else $error("crc4 status wrong");
    a_status_idle: assert property (@(posedge mclk) disable iff (srst)
        ##1 (status_r & 16'hfc10) == 16'h0000) else $error("unused status bit set");
    a_save_allow: assert property (@(posedge mclk) disable iff (srst)
        s_crc_clear ##0 save_req |=> save_go_r && !save_refused_r) else $error("save not allowed");
    a_refuse_only: assert property (@(posedge mclk) disable iff (srst)
        s_crc_clear |=> !save_refused_r) else $error("save refused without cause");

    // ****************************************
    // configuration and fault value checks
    // ****************************************
    a_float_swap: assert property (@(posedge mclk) disable iff (srst)
        s_float_read ##0 cfg_r[RTD_CFG_SWAP]
        |=> {16'h0000, rd_data_r} == ($past(float_r[0]) & 32'h0000_ffff)) else $error("swapped order wrong");
    a_cfg_steady: assert property (@(posedge mclk) disable iff (srst)
        !(req.wr && req.addr == RTD_CFG_ADDR) |=> $stable(cfg_r)) else $error("cfg changed unasked");
    a_lamp_in2: assert property (@(posedge mclk) disable iff (srst)
        in_err[1] && !cfg_r[6] |=> error_indicator_lamp_r) else $error("lamp not lit for input 2");
    a_lamp_in3: assert property (@(posedge mclk) disable iff (srst)
        in_err[2] && !cfg_r[5] |=> error_indicator_lamp_r) else $error("lamp not lit for input 3");
    a_lamp_in4: assert property (@(posedge mclk) disable iff (srst)
        in_err[3] && !cfg_r[4] |=> error_indicator_lamp_r) else $error("lamp not lit for input 4");
    a_lamp_quiet: assert property (@(posedge mclk) disable iff (srst)
        !(in_err[0] && !cfg_r[7]) && !(in_err[1] && !cfg_r[6])
        && !(in_err[2] && !cfg_r[5]) && !(in_err[3] && !cfg_r[4])
        |=> !error_indicator_lamp_r) else $error("lamp lit without cause");
    a_hold_in1: assert property (@(posedge mclk) disable iff (srst)
        in_err[0] && cfg_r[3] |=> $stable(word_r[0]) && $stable(float_r[0])) else $error("input 1 not held");
    a_hold_in2: assert property (@(posedge mclk) disable iff (srst)
        in_err[1] && cfg_r[2] |=> $stable(word_r[1]) && $stable(float_r[1])) else $error("input 2 not held");
    a_hold_in3: assert property (@(posedge mclk) disable iff (srst)
        in_err[2] && cfg_r[1] |=> $stable(word_r[2]) && $stable(float_r[2])) else $error("input 3 not held");
    a_subst_in2: assert property (@(posedge mclk) disable iff (srst)
        in_err[1] && !cfg_r[2] |=> word_r[1] == $past(fault_r[1])) else $error("input 2 fault missing");
    a_subst_in3: assert property (@(posedge mclk) disable iff (srst)
        in_err[2] && !cfg_r[1] |=> word_r[2] == $past(fault_r[2])) else $error("input 3 fault missing");
    a_subst_in4: assert property (@(posedge mclk) disable iff (srst)
        in_err[3] && !cfg_r[0] |=> word_r[3] == $past(fault_r[3])) else $error("input 4 fault missing");
    a_float_hold4: assert property (@(posedge mclk) disable iff (srst)
        in_err[3] && cfg_r[0] |=> $stable(float_r[3])) else $error("input 4 float not held");
    a_fault_write: assert property (@(posedge mclk) disable iff (srst)
        req.wr && req.addr == RTD_FAULT_ADDR |=> fault_r[0] == $past(req.wdata)) else $error("fault 1 not stored");
    a_fault_last: assert property (@(posedge mclk) disable iff (srst)
        req.wr && req.addr == RTD_FAULT_ADDR + 16'h0003 |=> fault_r[3] == $past(req.wdata)) else $error("fault 4 lost");
endmodule : rtd_regs

/* File: inc/rtd_pkg.sv */
// Purpose: constants and carriers for the rtd input status and configuration registers
// Assumes: 16-bit holding registers addressed by their register number
// Notes:   one clock, synchronous reset
package rtd_pkg;
    // ****************************************
    // register numbers
    // ****************************************
    localparam logic [15:0] RTD_STATUS_ADDR = 16'h9c42;
    localparam logic [15:0] RTD_WORD_ADDR   = 16'h9c43;
    localparam logic [15:0] RTD_FLOAT_ADDR  = 16'h9c47;
    localparam logic [15:0] RTD_CFG_ADDR    = 16'h9c69;
    localparam logic [15:0] RTD_FAULT_ADDR  = 16'h9c6a;
    localparam int          RTD_INPUTS      = 4;
    // ****************************************
    // reset values and fields
    // ****************************************
    localparam logic [15:0] RTD_CFG_RST     = 16'h0000;
    localparam logic [15:0] RTD_FAULT_RST   = 16'h2134;
    localparam int          RTD_CFG_SWAP    = 15;
    localparam int          RTD_CFG_LAMP    = 4;
    localparam logic [7:0]  RTD_F32_BIAS    = 8'h7f;
    localparam int          RTD_B_ACQ3      = 9;
    localparam int          RTD_B_CRC3      = 8;
    localparam int          RTD_B_SUPPLY    = 7;
    localparam int          RTD_B_RX        = 6;
    localparam int          RTD_B_MEM4      = 5;
    localparam int          RTD_B_RTD4      = 3;
    localparam int          RTD_B_WIRE4     = 2;
    localparam int          RTD_B_ACQ4      = 1;
    localparam int          RTD_B_CRC4      = 0;
    // ****************************************
    // carriers
    // ****************************************
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [15:0] wdata;
    } rtd_req_t;
    typedef struct packed {
        logic acq3;
        logic crc3;
        logic supply;
        logic rx;
        logic mem4;
        logic rtd4;
        logic wire4;
        logic three_wire4;
        logic acq4;
        logic crc4;
    } rtd_err_t;
endpackage : rtd_pkg

/* File: sim/rtd_input_status_config_regs_tb_top.sv */
// Purpose: self-checking bench for the status and configuration registers
// Assumes: inputs driven at the falling edge
// Notes:   float fault value of 8500 is 32'h4604d000
`timescale 1ns/10ps
module rtd_input_status_config_regs_tb_top;
    import rtd_pkg::*;
    logic         mclk, srst, save_req, rd_valid_r, addr_err_r, save_go_r, save_refused_r, lamp, ae;
    logic [3:0]   in_err, meas_valid;
    logic [63:0]  meas_word;
    logic [127:0] meas_float;
    logic [15:0]  rd_data_r, q;
    rtd_req_t     req;
    rtd_err_t     err;
    int           mismatches, cmp_count;
    rtd_mst mst (.mclk(mclk), .req(req), .rd_data_r(rd_data_r), .rd_valid_r(rd_valid_r), .addr_err_r(addr_err_r));
    rtd_regs uut (.mclk(mclk), .srst(srst), .req(req), .rd_data_r(rd_data_r), .rd_valid_r(rd_valid_r),
        .addr_err_r(addr_err_r), .err(err), .in_err(in_err), .meas_valid(meas_valid), .meas_word(meas_word),
        .meas_float(meas_float), .save_req(save_req), .save_go_r(save_go_r), .save_refused_r(save_refused_r),
        .error_indicator_lamp_r(lamp));
    // ****************************************
    // helpers
    // ****************************************
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic rd(input logic [15:0] a);
        mst.xfer(1'b0, a, 16'h0000, q, ae);
    endtask : rd
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        mst.xfer(1'b1, a, d, q, ae);
    endtask : wr
    task automatic close_out;
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : close_out
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset;
        rd(RTD_CFG_ADDR);
        chk(q, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            rd(RTD_FAULT_ADDR + 16'(i));
            chk(q, 16'h2134);
        end
        wr(RTD_FAULT_ADDR, 16'hfc18);
        rd(RTD_FAULT_ADDR);
        chk(q, 16'hfc18);
        wr(RTD_FAULT_ADDR, 16'h2134);
        rd(16'h9c00);
        chk({15'h0000, ae}, 16'h0001);
        $display("test reset done");
    endtask : t_reset
    task automatic t_status;
        logic [15:0] e [11] = '{16'h0200, 16'h0100, 16'h0080, 16'h0040, 16'h0020, 16'h0008,
                                16'h0000, 16'h0000, 16'h0002, 16'h0001, 16'h0004};
        for (int j = 0; j < 11; j++) begin
            @(negedge mclk);
            err = (j < 10) ? rtd_err_t'(10'h200 >> j) : rtd_err_t'(10'h00c);
            rd(RTD_STATUS_ADDR);
            chk(q, e[j]);
        end
        err = rtd_err_t'(10'h201);
        wr(RTD_STATUS_ADDR, 16'h0000);
        rd(RTD_STATUS_ADDR);
        chk(q, 16'h0201);
        err = '0;
        wr(RTD_STATUS_ADDR, 16'hffff);
        rd(RTD_STATUS_ADDR);
        chk(q, 16'h0000);
        $display("test status done");
    endtask : t_status
    task automatic t_save;
        logic [9:0] p [3] = '{10'h100, 10'h001, 10'h000};
        for (int j = 0; j < 3; j++) begin
            @(negedge mclk);
            err = rtd_err_t'(p[j]);
            @(negedge mclk);
            save_req = 1'b1;
            @(negedge mclk);
            save_req = 1'b0;
            chk({14'h0000, save_go_r, save_refused_r}, (j < 2) ? 16'h0001 : 16'h0002);
        end
        err = '0;
        $display("test save done");
    endtask : t_save
    task automatic t_lamp;
        in_err = 4'hf;
        wr(RTD_CFG_ADDR, 16'h7f00);
        rd(RTD_CFG_ADDR);
        chk(q, 16'h7f00);
        chk({15'h0000, lamp}, 16'h0001);
        for (int i = 0; i < 4; i++) begin
            in_err = 4'(1 << i);
            wr(RTD_CFG_ADDR, 16'h0000);
            repeat (2) @(negedge mclk);
            chk({15'h0000, lamp}, 16'h0001);
            wr(RTD_CFG_ADDR, 16'(1 << (7 - i)));
            repeat (2) @(negedge mclk);
            chk({15'h0000, lamp}, 16'h0000);
        end
        in_err = 4'h0;
        $display("test lamp done");
    endtask : t_lamp
    task automatic t_subst;
        for (int i = 0; i < 4; i++) begin
            wr(RTD_CFG_ADDR, 16'h0000);
            meas_word[16*i +: 16] = 16'h0123 + 16'(i);
            meas_valid = 4'(1 << i);
            @(negedge mclk);
            meas_valid = 4'h0;
            wr(RTD_CFG_ADDR, 16'(1 << (3 - i)));
            in_err = 4'(1 << i);
            repeat (2) @(negedge mclk);
            rd(RTD_WORD_ADDR + 16'(i));
            chk(q, 16'h0123 + 16'(i));
            rd(RTD_FLOAT_ADDR + 16'(2 * i));
            chk(q, 16'h3f80);
            wr(RTD_CFG_ADDR, 16'h0000);
            repeat (2) @(negedge mclk);
            rd(RTD_WORD_ADDR + 16'(i));
            chk(q, 16'h2134);
            rd(RTD_FLOAT_ADDR + 16'(2 * i));
            chk(q, 16'h4604);
            wr(RTD_CFG_ADDR, 16'h8000);
            rd(RTD_FLOAT_ADDR + 16'(2 * i));
            chk(q, 16'hd000);
            rd(RTD_FLOAT_ADDR + 16'(2 * i + 1));
            chk(q, 16'h4604);
            in_err = 4'h0;
        end
        $display("test subst done");
    endtask : t_subst
    // ****************************************
    // run
    // ****************************************
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    initial begin
        repeat (20000) @(posedge mclk);
        mismatches++;
        close_out();
    end
    initial begin
        srst = 1'b1;
        save_req = 1'b0;
        err = '0;
        in_err = 4'h0;
        meas_valid = 4'h0;
        meas_word = '0;
        meas_float = {4{32'h3f800000}};
        mismatches = 0;
        cmp_count = 0;
        repeat (20) @(negedge mclk);
        srst = 1'b0;
        t_reset();
        t_status();
        t_save();
        t_lamp();
        t_subst();
        close_out();
    end
endmodule : rtd_input_status_config_regs_tb_top

/* File: sim/rtd_mst.sv */
// Purpose: register master standing in for the serial frame decoder
// Assumes: one request per access, answer one cycle later
// Notes:   released address and data lines show the inverse of the last value
`timescale 1ns/10ps
module rtd_mst (
    // clock
    input  wire logic         mclk,
    // register access
    output rtd_pkg::rtd_req_t req,
    input  wire logic [15:0]  rd_data_r,
    input  wire logic         rd_valid_r,
    input  wire logic         addr_err_r
);
    import rtd_pkg::*;
    initial req = '0;
    // one access: drive after falling edge, answer taken at the next falling edge, half a cycle after acceptance
    task automatic xfer(input logic w, input logic [15:0] a, input logic [15:0] d,
                        output logic [15:0] q, output logic ae);
        @(negedge mclk);
        req <= '{wr: w, rd: ~w, addr: a, wdata: d};
        @(negedge mclk);
        req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
        q = (rd_valid_r === 1'b1) ? rd_data_r : 16'hxxxx;
        ae = addr_err_r;
    endtask : xfer
endmodule : rtd_mst
